/* File: hdl/macdp_datapath.sv */
`timescale 1ns/1ns
// Overview of operation
// - Extend 16-bit operands to 17 bits by signedness
// - 33-bit product, sign-extended to 40 bits
// - Scaler picks Q31 fractional or integer product
// - Fractional product is 1.31, shifted left once
// - Same multiplier runs integer multiply, any signedness
// - Byte operands give 16 bits, words 32
// - 40-bit adder; selected accumulator is source, destination
// - Add and load data optionally barrel-shifted first
// - One adder input zeroable, other true/complement
// - Carry in low for add, high (no borrow) for subtract
// - Overflow out of bit 39 is catastrophic
// - Guard overflow when bits 32-39 differ
// - Saturation uses result, flags, enables, width select
// - Status shows OR of guard and clip flags
// - Guard flags rewritten on every adder pass
// - Guard flag with its enable raises trap
// - Clip flags sticky; only software clears them
// - Clip flag past selected range; saturate if enabled
// - Saturation off: clip flag records bit-39 overflow
// - Wrap enable, saturation off, clip sets trap
module macdp_datapath (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [macdp_pkg::ADDR_W-1:0] addr_i,
   input wire logic [macdp_pkg::DATA_W-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [macdp_pkg::DATA_W-1:0] rd_data_o,
   input wire logic op_valid_i,
   input wire macdp_pkg::macdp_op_t op_i,
   input wire logic acc_sel_i,
   input wire logic [15:0] opnd_a_i,
   input wire logic [15:0] opnd_b_i,
   input wire logic signed_a_i,
   input wire logic signed_b_i,
   input wire logic byte_mode_i,
   input wire logic [39:0] add_data_i,
   input wire logic add_sub_i,
   input wire logic shift_en_i,
   input wire logic shift_left_i,
   input wire logic [3:0] shift_amt_i,
   output logic [31:0] int_result_o,
   output logic int_valid_o,
   output logic trap_o
);
   import macdp_pkg::*;

   logic [15:0] core_control_reg;
   logic [15:0] trap_control_reg;
   logic [39:0] acc [2];
   logic guard_ovf [2];
   logic clip_flag [2];
   logic any_guard_ovf_flag;
   logic any_clip_flag;

   wire step = ce_i && op_valid_i;
   wire frac_mode = core_control_reg[CC_FRAC_BIT];
   wire clip_width_select = core_control_reg[CC_WIDTH_BIT];
   wire [1:0] clip_enable_pair = {core_control_reg[CC_CLIP_FIRST_BIT], core_control_reg[CC_CLIP_SECOND_BIT]};
   wire guard_trap_en_first = trap_control_reg[TC_GUARD_FIRST_BIT];
   wire guard_trap_en_second = trap_control_reg[TC_GUARD_SECOND_BIT];
   wire wrap_trap_en = trap_control_reg[TC_WRAP_BIT];
   wire first_acc_guard_ovf = guard_ovf[0];
   wire second_acc_guard_ovf = guard_ovf[1];
   wire first_acc_clip_flag = clip_flag[0];
   wire second_acc_clip_flag = clip_flag[1];
   wire [39:0] accum_first = acc[0];
   wire [39:0] accum_second = acc[1];

   // Operation decode
   wire is_prod_op = (op_i == MACDP_OP_MAC) || (op_i == MACDP_OP_MSC) || (op_i == MACDP_OP_MPY);
   wire is_acc_op = is_prod_op || (op_i == MACDP_OP_ADD) || (op_i == MACDP_OP_LAC);
   wire int_product_op = (op_i == MACDP_OP_MUL);
   wire accum_load_op = (op_i == MACDP_OP_LAC);
   wire zero_sel = (op_i == MACDP_OP_MPY) || accum_load_op;
   wire sub_sel = (op_i == MACDP_OP_MSC) || ((op_i == MACDP_OP_ADD) && add_sub_i);

   // Multiplier operands; byte integer multiplies narrow to the low byte first
   wire use_byte = int_product_op && byte_mode_i;
   wire [15:0] src_a = use_byte ? {{8{signed_a_i & opnd_a_i[7]}}, opnd_a_i[7:0]} : opnd_a_i;
   wire [15:0] src_b = use_byte ? {{8{signed_b_i & opnd_b_i[7]}}, opnd_b_i[7:0]} : opnd_b_i;
   wire [16:0] ext_a = {signed_a_i & src_a[15], src_a};
   wire [16:0] ext_b = {signed_b_i & src_b[15], src_b};
   wire signed [33:0] raw_prod = $signed(ext_a) * $signed(ext_b);
   wire [32:0] int_prod = raw_prod[32:0];
   wire [32:0] frac_prod = {raw_prod[31:0], 1'b0};
   wire [32:0] scaled_prod = frac_mode ? frac_prod : int_prod;
   wire [39:0] prod40 = {{7{scaled_prod[32]}}, scaled_prod};
   wire [31:0] int_expect = byte_mode_i ? {16'h0000, int_prod[15:0]} : int_prod[31:0];

   // Optional pre-shift of add/load data
   wire [39:0] shl_data = add_data_i << shift_amt_i;
   wire [39:0] shr_data = $unsigned($signed(add_data_i) >>> shift_amt_i);
   wire [39:0] shift_data = shift_en_i ? (shift_left_i ? shl_data : shr_data) : add_data_i;

   // Adder/subtracter
   wire [39:0] acc_cur = acc_sel_i ? acc[1] : acc[0];
   wire [39:0] add_x = zero_sel ? ACC_RST : acc_cur;
   wire [39:0] data_sel = is_prod_op ? prod40 : shift_data;
   wire [39:0] add_y = sub_sel ? ~data_sel : data_sel;
   // Borrow is active low: no borrow pending feeds a one into the carry
   wire carry_in = sub_sel;
   wire [40:0] add_full = {1'b0, add_x} + {1'b0, add_y} + {40'h0000000000, carry_in};
   wire [39:0] sum = add_full[39:0];
   wire wrap_ovf = (add_x[39] == add_y[39]) && (sum[39] != add_x[39]);
   wire guard_hit = !((sum[39:32] == 8'h00) || (sum[39:32] == 8'hFF));
   wire range32_hit = !((sum[39:31] == 9'h000) || (sum[39:31] == 9'h1FF));
   // True sign is the input sign when bit 39 wrapped
   wire true_neg = wrap_ovf ? add_x[39] : sum[39];
   wire sel_clip_en = acc_sel_i ? clip_enable_pair[0] : clip_enable_pair[1];
   wire range_hit = clip_width_select ? wrap_ovf : (wrap_ovf || range32_hit);
   wire clip_hit = sel_clip_en ? range_hit : wrap_ovf;
   wire [39:0] clamp_pos = clip_width_select ? CLAMP40_POS : CLAMP32_POS;
   wire [39:0] clamp_neg = clip_width_select ? CLAMP40_NEG : CLAMP32_NEG;
   wire [39:0] clamp_val = true_neg ? clamp_neg : clamp_pos;
   wire [39:0] acc_result = (sel_clip_en && range_hit) ? clamp_val : sum;
   wire sel_guard_en = acc_sel_i ? guard_trap_en_second : guard_trap_en_first;
   wire trap_event = is_acc_op && ((guard_hit && sel_guard_en) || (wrap_trap_en && !sel_clip_en && clip_hit));

   // Register port decode
   wire wr_core = ce_i && wr_i && (addr_i == CORE_CONTROL_REG);
   wire wr_trap = ce_i && wr_i && (addr_i == TRAP_CONTROL_REG);
   wire wr_status = ce_i && wr_i && (addr_i == STATUS_REG);
   wire [15:0] status_word = {10'h000, any_clip_flag, any_guard_ovf_flag, second_acc_clip_flag,
                              first_acc_clip_flag, second_acc_guard_ovf, first_acc_guard_ovf};
   logic [15:0] next_rd_data;
   always_comb begin
      if (addr_i == CORE_CONTROL_REG) begin
         next_rd_data = core_control_reg;
      end else if (addr_i == TRAP_CONTROL_REG) begin
         next_rd_data = trap_control_reg;
      end else if (addr_i == STATUS_REG) begin
         next_rd_data = status_word;
      end else if (addr_i == ACCUM_FIRST_LO) begin
         next_rd_data = accum_first[15:0];
      end else if (addr_i == ACCUM_FIRST_MID) begin
         next_rd_data = accum_first[31:16];
      end else if (addr_i == ACCUM_FIRST_HI) begin
         next_rd_data = {8'h00, accum_first[39:32]};
      end else if (addr_i == ACCUM_SECOND_LO) begin
         next_rd_data = accum_second[15:0];
      end else if (addr_i == ACCUM_SECOND_MID) begin
         next_rd_data = accum_second[31:16];
      end else if (addr_i == ACCUM_SECOND_HI) begin
         next_rd_data = {8'h00, accum_second[39:32]};
      end else if (addr_i == INT_RESULT_LO) begin
         next_rd_data = int_result_o[15:0];
      end else if (addr_i == INT_RESULT_HI) begin
         next_rd_data = int_result_o[31:16];
      end else begin
         next_rd_data = 16'h0000;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rd_data_o <= 16'h0000;
      end else if (ce_i) begin
         rd_data_o <= rd_i ? next_rd_data : 16'h0000;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         core_control_reg <= CORE_CONTROL_RST;
         trap_control_reg <= TRAP_CONTROL_RST;
      end else begin
         if (wr_core) begin
            core_control_reg <= wr_data_i & CORE_CONTROL_MASK;
         end
         if (wr_trap) begin
            trap_control_reg <= wr_data_i & TRAP_CONTROL_MASK;
         end
      end
   end

   // Per-accumulator state
   logic [1:0] next_guard;
   logic [1:0] next_clip;
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_acc
         wire hit = step && is_acc_op && (acc_sel_i == 1'(gi));
         wire clr_bit = wr_status && wr_data_i[ST_CLIP_FIRST_BIT + gi];
         // A clip event in the clearing cycle keeps the flag set
         assign next_clip[gi] = (hit && clip_hit) || (clip_flag[gi] && !clr_bit);
         assign next_guard[gi] = hit ? guard_hit : guard_ovf[gi];
         always_ff @(posedge mclk_i) begin
            if (rst_i) begin
               acc[gi] <= ACC_RST;
               guard_ovf[gi] <= 1'b0;
               clip_flag[gi] <= 1'b0;
            end else if (ce_i) begin
               if (hit) begin
                  acc[gi] <= acc_result;
               end
               guard_ovf[gi] <= next_guard[gi];
               clip_flag[gi] <= next_clip[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         any_guard_ovf_flag <= 1'b0;
         any_clip_flag <= 1'b0;
         trap_o <= 1'b0;
         int_valid_o <= 1'b0;
         int_result_o <= INT_RESULT_RST;
      end else if (ce_i) begin
         any_guard_ovf_flag <= next_guard[0] | next_guard[1];
         any_clip_flag <= next_clip[0] | next_clip[1];
         trap_o <= step && trap_event;
         int_valid_o <= step && int_product_op;
         if (step && int_product_op) begin
            int_result_o <= int_expect;
         end
      end
   end

   // Checks
   opnd_extend_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      op_valid_i |-> (ext_a[16] == (signed_a_i & src_a[15])) && (ext_b[16] == (signed_b_i & src_b[15])))
      else $error("operand extension wrong");
   prod_sext_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      $signed(prod40) == $signed(scaled_prod))
      else $error("product not sign extended");
   frac_scale_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (step && (op_i == MACDP_OP_MPY) && frac_mode && !range_hit && !wrap_ovf)
      |=> acc[$past(acc_sel_i)] == {{7{$past(raw_prod[31])}}, $past(raw_prod[31:0]), 1'b0})
      else $error("fractional product not scaled");
   int_mul_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (step && int_product_op) |=> int_valid_o && (int_result_o == $past(int_expect)))
      else $error("integer product wrong");
   acc_other_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (step && is_acc_op && !acc_sel_i) |=> $stable(acc[1]))
      else $error("unselected accumulator changed");
   load_path_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (step && accum_load_op && !acc_sel_i && !clip_enable_pair[1]) |=> acc[0] == $past(shift_data))
      else $error("load did not pass shifted data");
   sub_path_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (step && (op_i == MACDP_OP_MSC) && !sel_clip_en)
      |=> acc[$past(acc_sel_i)] == 40'($past(acc_cur) - $past(prod40)))
      else $error("subtract result wrong");
   // A clamped result no longer shows the guard bits the flag was taken from
   guard_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (step && is_acc_op && !(sel_clip_en && range_hit)) |=> guard_ovf[$past(acc_sel_i)] ==
      !((acc[$past(acc_sel_i)][39:32] == 8'h00) || (acc[$past(acc_sel_i)][39:32] == 8'hFF)))
      else $error("guard flag does not match result");
   clip_sticky_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      $fell(clip_flag[0]) |-> $past(rst_i) || $past(wr_status && wr_data_i[ST_CLIP_FIRST_BIT]))
      else $error("clip flag cleared by hardware");
   clip_clamp_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (step && is_acc_op && sel_clip_en && range_hit)
      |=> acc[$past(acc_sel_i)] == $past(clamp_val) && clip_flag[$past(acc_sel_i)])
      else $error("saturation clamp wrong");
   wrap_trap_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (step && is_acc_op && wrap_trap_en && !sel_clip_en && wrap_ovf) |=> trap_o)
      else $error("wrap trap missing");
   guard_trap_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (step && is_acc_op && guard_hit && sel_guard_en) |=> trap_o ##1 !trap_o || $past(step))
      else $error("guard trap missing");
   any_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i |=> (any_clip_flag == (clip_flag[0] | clip_flag[1]))
      && (any_guard_ovf_flag == (guard_ovf[0] | guard_ovf[1])))
      else $error("summary flags disagree");
   ce_freeze_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      !ce_i |=> $stable(acc[0]) && $stable(acc[1]) && $stable(trap_o) && $stable(rd_data_o)
      && $stable(core_control_reg) && $stable(clip_flag[0]) && $stable(int_valid_o))
      else $error("state changed with clock enable low");
   rd_idle_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && !rd_i) |=> (rd_data_o == 16'h0000))
      else $error("read data not idle");
   freeze_seen_c: cover property (@(posedge mclk_i) !ce_i && op_valid_i);
   mac_seen_c: cover property (@(posedge mclk_i) step && (op_i == MACDP_OP_MAC) ##1 step && (op_i == MACDP_OP_MAC));
   clamp_seen_c: cover property (@(posedge mclk_i) step && is_acc_op && sel_clip_en && range_hit);
   trap_seen_c: cover property (@(posedge mclk_i) trap_o);
   byte_mul_c: cover property (@(posedge mclk_i) step && int_product_op && byte_mode_i && signed_a_i);
endmodule

/* File: hdl/macdp_pkg.sv */
package macdp_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ACC_W = 40;
   localparam int unsigned OPND_W = 17;
   localparam int unsigned PROD_W = 33;
   // Register indices
   localparam logic [3:0] CORE_CONTROL_REG = 4'h0;
   localparam logic [3:0] TRAP_CONTROL_REG = 4'h1;
   localparam logic [3:0] STATUS_REG = 4'h2;
   localparam logic [3:0] ACCUM_FIRST_LO = 4'h3;
   localparam logic [3:0] ACCUM_FIRST_MID = 4'h4;
   localparam logic [3:0] ACCUM_FIRST_HI = 4'h5;
   localparam logic [3:0] ACCUM_SECOND_LO = 4'h6;
   localparam logic [3:0] ACCUM_SECOND_MID = 4'h7;
   localparam logic [3:0] ACCUM_SECOND_HI = 4'h8;
   localparam logic [3:0] INT_RESULT_LO = 4'h9;
   localparam logic [3:0] INT_RESULT_HI = 4'hA;
   // core_control_reg fields
   localparam int unsigned CC_FRAC_BIT = 0;
   localparam int unsigned CC_WIDTH_BIT = 4;
   localparam int unsigned CC_CLIP_SECOND_BIT = 6;
   localparam int unsigned CC_CLIP_FIRST_BIT = 7;
   localparam logic [15:0] CORE_CONTROL_RST = 16'h0000;
   localparam logic [15:0] CORE_CONTROL_MASK = 16'h00D1;
   // trap_control_reg fields
   localparam int unsigned TC_WRAP_BIT = 8;
   localparam int unsigned TC_GUARD_SECOND_BIT = 9;
   localparam int unsigned TC_GUARD_FIRST_BIT = 10;
   localparam logic [15:0] TRAP_CONTROL_RST = 16'h0000;
   localparam logic [15:0] TRAP_CONTROL_MASK = 16'h0700;
   // Status fields
   localparam int unsigned ST_GUARD_FIRST_BIT = 0;
   localparam int unsigned ST_GUARD_SECOND_BIT = 1;
   localparam int unsigned ST_CLIP_FIRST_BIT = 2;
   localparam int unsigned ST_CLIP_SECOND_BIT = 3;
   localparam int unsigned ST_ANY_GUARD_BIT = 4;
   localparam int unsigned ST_ANY_CLIP_BIT = 5;
   // Clamp and reset values
   localparam logic [39:0] CLAMP32_POS = 40'h007FFFFFFF;
   localparam logic [39:0] CLAMP32_NEG = 40'hFF80000000;
   localparam logic [39:0] CLAMP40_POS = 40'h7FFFFFFFFF;
   localparam logic [39:0] CLAMP40_NEG = 40'h8000000000;
   localparam logic [39:0] ACC_RST = 40'h0000000000;
   localparam logic [31:0] INT_RESULT_RST = 32'h00000000;
   typedef enum logic [5:0] {
      MACDP_OP_MAC = 6'h01,
      MACDP_OP_MSC = 6'h02,
      MACDP_OP_MPY = 6'h04,
      MACDP_OP_ADD = 6'h08,
      MACDP_OP_LAC = 6'h10,
      MACDP_OP_MUL = 6'h20
   } macdp_op_t;
endpackage

/* File: bench/macdp_wreg.sv */
`timescale 1ns/1ns
// Working register pair that takes integer products; a byte product leaves the high word alone
module macdp_wreg (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic int_valid_i,
   input wire logic [31:0] int_result_i,
   input wire logic byte_i,
   output logic [15:0] w_lo_o,
   output logic [15:0] w_hi_o
);
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         w_lo_o <= 16'h0000;
         w_hi_o <= 16'h0000;
      end else if (int_valid_i) begin
         w_lo_o <= int_result_i[15:0];
         if (!byte_i) begin
            w_hi_o <= int_result_i[31:16];
         end
      end
   end
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   import macdp_pkg::*;
   logic mclk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, op_valid_i = 1'b0;
   logic acc_sel_i = 1'b0, signed_a_i = 1'b0, signed_b_i = 1'b0, byte_mode_i = 1'b0, add_sub_i = 1'b0;
   logic shift_en_i = 1'b0, shift_left_i = 1'b0, int_valid_o, trap_o, seen_trap, seen_valid;
   logic [3:0] addr_i = 4'h0, shift_amt_i = 4'h0;
   logic [15:0] wr_data_i = 16'h0000, opnd_a_i = 16'h0000, opnd_b_i = 16'h0000;
   logic [15:0] rd_data_o, w_lo, w_hi, exp_hi;
   logic [39:0] add_data_i = 40'h0000000000;
   logic [31:0] int_result_o;
   macdp_op_t op_i = MACDP_OP_MAC;
   int num_errors = 0;
   int n_checks = 0;
   // Product rows: operand a, operand b, {byte, signed a, signed b}, expected result
   logic [15:0] ta [6] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h12FF, 16'h12FF, 16'h8000};
   logic [15:0] tb [6] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h3402, 16'h3402, 16'h8000};
   logic [2:0] tm [6] = '{3'h3, 3'h0, 3'h2, 3'h7, 3'h4, 3'h3};
   logic [31:0] te [6] = '{32'h00000001, 32'hFFFE0001, 32'hFFFF0001, 32'h0000FFFE, 32'h000001FE, 32'h40000000};
   macdp_datapath dut (.mclk_i, .rst_i, .ce_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .op_valid_i, .op_i,
      .acc_sel_i, .opnd_a_i, .opnd_b_i, .signed_a_i, .signed_b_i, .byte_mode_i, .add_data_i, .add_sub_i,
      .shift_en_i, .shift_left_i, .shift_amt_i, .int_result_o, .int_valid_o, .trap_o);
   macdp_wreg wreg (.mclk_i, .rst_i, .int_valid_i(int_valid_o), .int_result_i(int_result_o),
      .byte_i(byte_mode_i), .w_lo_o(w_lo), .w_hi_o(w_hi));
   initial begin
      forever #2 mclk_i = ~mclk_i;
   end
   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk_val(input string what, input logic [39:0] exp, input logic [39:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge mclk_i);
      addr_i <= a;
      wr_data_i <= v;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe edge
   task automatic reg_rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 v = rd_data_o;
   endtask
   task automatic chk_rd(input logic [3:0] a, input logic [15:0] e);
      logic [15:0] v;
      reg_rd(a, v);
      chk_val("rd_data", {24'h000000, e}, {24'h000000, v});
   endtask
   task automatic chk_acc(input logic sel, input logic [39:0] e);
      logic [15:0] lo, mid, hi;
      reg_rd(sel ? ACCUM_SECOND_LO : ACCUM_FIRST_LO, lo);
      reg_rd(sel ? ACCUM_SECOND_MID : ACCUM_FIRST_MID, mid);
      reg_rd(sel ? ACCUM_SECOND_HI : ACCUM_FIRST_HI, hi);
      chk_val("accumulator", e, {hi[7:0], mid, lo});
   endtask
   task automatic issue(input macdp_op_t o, input logic sel, input logic [15:0] a, input logic [15:0] b,
      input logic [2:0] m, input logic [39:0] data, input logic sub);
      @(posedge mclk_i);
      op_valid_i <= 1'b1;
      op_i <= o;
      acc_sel_i <= sel;
      opnd_a_i <= a;
      opnd_b_i <= b;
      {byte_mode_i, signed_a_i, signed_b_i} <= m;
      add_data_i <= data;
      add_sub_i <= sub;
      @(posedge mclk_i);
      op_valid_i <= 1'b0;
      #1 seen_trap = trap_o;
      seen_valid = int_valid_o;
   endtask
   task automatic mop(input macdp_op_t o, input logic sel, input logic [15:0] a, input logic [15:0] b,
      input logic [2:0] m);
      issue(o, sel, a, b, m, 40'h0000000000, 1'b0);
   endtask
   task automatic aop(input macdp_op_t o, input logic sel, input logic [39:0] data, input logic sub);
      issue(o, sel, 16'h0000, 16'h0000, 3'h0, data, sub);
   endtask
   initial begin
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      chk_rd(STATUS_REG, 16'h0000);
      chk_rd(4'hB, 16'h0000);
      exp_hi = 16'h0000;
      for (int i = 0; i < 6; i++) begin
         mop(MACDP_OP_MUL, 1'b0, ta[i], tb[i], tm[i]);
         chk_bit("int_valid", 1'b1, seen_valid);
         chk_val("int_result", {8'h00, te[i]}, {8'h00, int_result_o});
         @(posedge mclk_i);
         #1 exp_hi = tm[i][2] ? exp_hi : te[i][31:16];
         chk_val("wreg", {8'h00, exp_hi, te[i][15:0]}, {8'h00, w_hi, w_lo});
         chk_bit("int_valid_end", 1'b0, int_valid_o);
      end
      reg_wr(CORE_CONTROL_REG, 16'h0001);
      mop(MACDP_OP_MPY, 1'b0, 16'h4000, 16'h4000, 3'h3);
      chk_acc(1'b0, 40'h0020000000);
      reg_wr(CORE_CONTROL_REG, 16'h0000);
      mop(MACDP_OP_MPY, 1'b1, 16'hFFFF, 16'h0001, 3'h3);
      chk_acc(1'b1, 40'hFFFFFFFFFF);
      mop(MACDP_OP_MPY, 1'b0, 16'hFFFF, 16'h0001, 3'h0);
      mop(MACDP_OP_MAC, 1'b0, 16'h0002, 16'h0003, 3'h3);
      chk_acc(1'b0, 40'h0000010005);
      mop(MACDP_OP_MSC, 1'b1, 16'h0001, 16'h0001, 3'h3);
      chk_acc(1'b1, 40'hFFFFFFFFFE);
      @(posedge mclk_i);
      {shift_en_i, shift_left_i, shift_amt_i} <= {1'b1, 1'b1, 4'h4};
      aop(MACDP_OP_LAC, 1'b0, 40'h0000000001, 1'b0);
      chk_acc(1'b0, 40'h0000000010);
      @(posedge mclk_i);
      shift_en_i <= 1'b0;
      aop(MACDP_OP_ADD, 1'b1, 40'h0000000005, 1'b1);
      chk_acc(1'b1, 40'hFFFFFFFFF9);
      aop(MACDP_OP_ADD, 1'b1, 40'h0000000010, 1'b0);
      chk_acc(1'b1, 40'h0000000009);
      reg_wr(TRAP_CONTROL_REG, 16'h0400);
      aop(MACDP_OP_LAC, 1'b0, 40'h00FFFFFFFF, 1'b0);
      aop(MACDP_OP_ADD, 1'b0, 40'h0000000001, 1'b0);
      chk_bit("trap", 1'b1, seen_trap);
      chk_rd(STATUS_REG, 16'h0011);
      // Read data falls back to zero in the cycle after it stood
      @(posedge mclk_i);
      #1 chk_val("rd_idle", 40'h0000000000, {24'h000000, rd_data_o});
      aop(MACDP_OP_LAC, 1'b1, 40'h00FFFFFFFF, 1'b0);
      aop(MACDP_OP_ADD, 1'b1, 40'h0000000001, 1'b0);
      chk_bit("trap", 1'b0, seen_trap);
      aop(MACDP_OP_LAC, 1'b0, 40'h0000000000, 1'b0);
      chk_rd(STATUS_REG, 16'h0012);
      reg_wr(TRAP_CONTROL_REG, 16'h0100);
      aop(MACDP_OP_LAC, 1'b0, 40'h7FFFFFFFFF, 1'b0);
      aop(MACDP_OP_ADD, 1'b0, 40'h0000000001, 1'b0);
      chk_bit("trap", 1'b1, seen_trap);
      chk_acc(1'b0, 40'h8000000000);
      chk_rd(STATUS_REG, 16'h0037);
      aop(MACDP_OP_LAC, 1'b0, 40'h0000000000, 1'b0);
      aop(MACDP_OP_LAC, 1'b1, 40'h0000000000, 1'b0);
      chk_rd(STATUS_REG, 16'h0024);
      reg_wr(STATUS_REG, 16'h0004);
      chk_rd(STATUS_REG, 16'h0000);
      reg_wr(CORE_CONTROL_REG, 16'h0080);
      aop(MACDP_OP_LAC, 1'b0, 40'h007FFFFFFF, 1'b0);
      aop(MACDP_OP_ADD, 1'b0, 40'h0000000001, 1'b0);
      chk_bit("trap", 1'b0, seen_trap);
      chk_acc(1'b0, CLAMP32_POS);
      chk_rd(STATUS_REG, 16'h0024);
      reg_wr(STATUS_REG, 16'h0004);
      reg_wr(CORE_CONTROL_REG, 16'h0090);
      aop(MACDP_OP_LAC, 1'b0, 40'h8000000000, 1'b0);
      aop(MACDP_OP_ADD, 1'b0, 40'h0000000001, 1'b1);
      chk_acc(1'b0, CLAMP40_NEG);
      chk_rd(STATUS_REG, 16'h0035);
      reg_wr(CORE_CONTROL_REG, 16'h0040);
      aop(MACDP_OP_LAC, 1'b1, 40'hFF80000000, 1'b0);
      aop(MACDP_OP_ADD, 1'b1, 40'h0000000001, 1'b1);
      chk_bit("trap", 1'b0, seen_trap);
      chk_acc(1'b1, CLAMP32_NEG);
      chk_rd(STATUS_REG, 16'h003D);
      // Clock enable low: the op and the write are both ignored
      @(posedge mclk_i);
      ce_i <= 1'b0;
      aop(MACDP_OP_LAC, 1'b0, 40'h0000001234, 1'b0);
      reg_wr(CORE_CONTROL_REG, 16'h0001);
      ce_i <= 1'b1;
      chk_acc(1'b0, CLAMP40_NEG);
      chk_rd(CORE_CONTROL_REG, 16'h0040);
      // Reset in mid-run clears registers, flags and accumulators
      @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      #1 chk_val("int_result_rst", 40'h0000000000, {8'h00, int_result_o});
      chk_rd(STATUS_REG, 16'h0000);
      chk_acc(1'b1, ACC_RST);
      chk_rd(CORE_CONTROL_REG, 16'h0000);
      finish_test;
   end
   // About 200 cycles of tests; this bound leaves ample margin
   initial begin
      #40000;
      num_errors++;
      finish_test;
   end
endmodule
